// >>> ffsp_defs.vh
/*
  Constants for the fast framed serial port pair: APB register map,
  control field positions, reset values and bit clock timing counts.
  Assumes a 40 MHz system clock and inclusion by every design file.
*/
// Contract
// - Tx frame sync direction selectable, input after reset
// - Tx bit clock direction selectable, input, shifts out
// - Rx frame sync direction selectable, input after reset
// - Rx bit clock direction selectable, input, samples data
// - Bit clock between 512 KHz and 8.192 MHz
// - Tx sync and data launch edge selectable
// - Rx data sample edge selectable
// - Tx data open drain: drive low only
// - Two independent ports, numbered 0 and 1
// - Sync and clock pins undriven until outputs
`ifndef FFSP_DEFS_VH
`define FFSP_DEFS_VH

// Register byte offsets, one aligned word each
`define FFSP_CTRL0_OFS 12'h000
`define FFSP_CTRL1_OFS 12'h004
`define FFSP_STAT0_OFS 12'h008
`define FFSP_STAT1_OFS 12'h00C
`define FFSP_TXDATA0_OFS 12'h010
`define FFSP_TXDATA1_OFS 12'h014
`define FFSP_RXDATA0_OFS 12'h018
`define FFSP_RXDATA1_OFS 12'h01C

// Control register field positions
`define FFSP_C_TXFS_OUT 0
`define FFSP_C_TXCK_OUT 1
`define FFSP_C_RXFS_OUT 2
`define FFSP_C_RXCK_OUT 3
`define FFSP_C_TX_FALL 4
`define FFSP_C_RX_FALL 5
`define FFSP_C_ENABLE 6
`define FFSP_CTRL_W 7
`define FFSP_CTRL_RST 7'h00

// Status register field positions
`define FFSP_S_TX_READY 0
`define FFSP_S_RX_VALID 1
`define FFSP_S_RX_OVERRUN 2

// Word length and frame length in bits
`define FFSP_WORD_W 8
`define FFSP_FRAME_BITS 8'h20

// Generated bit clock: 40 MHz / (2 * 5) = 4 MHz, within range
`define FFSP_SYS_KHZ 40000
`define FFSP_BCLK_KHZ 4000
`define FFSP_HALF_CYC ((`FFSP_SYS_KHZ + 2 * `FFSP_BCLK_KHZ - 1) / (2 * `FFSP_BCLK_KHZ))
`define FFSP_DIV_W 4

`endif

// >>> ffsp_framer.sv
/*
  Behavioural framer facing serial port 0: runs the bit clock only
  within a frame, drives both syncs and rx data, captures tx words.
  Assumes the bench resolves the open-drain tx line with a pull-up.
*/
`default_nettype none
module ffsp_framer (
  input wire logic tx_line,
  output logic ck,
  output logic tx_fs,
  output logic rx_fs,
  output logic rx_sd,
  output logic [7:0] got,
  output logic got_stb
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 100; // 200 ns bit period, 5 MHz
  // Idle levels; the rx line rests at its pull-up
  initial begin
    ck = 1'b0;
    tx_fs = 1'b0;
    rx_fs = 1'b0;
    rx_sd = 1'b1;
    got = 8'h00;
    got_stb = 1'b0;
  end
  // One frame; the first edge is the device's launch edge
  task automatic frame(input logic fall, input logic [7:0] rw);
    ck = fall;
    #HALF;
    for (int i = 0; i < 10; i++) begin
      ck = ~ck;
      tx_fs = (i == 0); // Sync on the launching edge
      #HALF;
      ck = ~ck;
      rx_fs = (i == 0); // Rx launched opposite the sampling edge
      rx_sd = (i < 8) ? rw[7 - i] : ~rx_sd;
      // Taken late in the bit: the device launches after its synchroniser
      #(HALF - 10);
      if (i >= 1 && i <= 8) begin
        got[8 - i] = tx_line;
      end
      #10;
    end
    rx_sd = 1'b1;
    got_stb = 1'b1;
    #HALF;
    got_stb = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> ffsp_monitor.sv
/*
  Checker bound to ffsp_top: pin enables follow the control words,
  tx data only pulls low, port 1 clock rate and launch edge.
  Assumes zero-wait APB writes to the control words.
*/
`default_nettype none
`include "ffsp_defs.vh"
module ffsp_monitor (
  input wire logic CLK_SYS_IN,
  input wire logic SYS_RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [1:0] TX_FS_OUT,
  input wire logic [1:0] TX_FS_OE_OUT,
  input wire logic [1:0] TX_CK_OUT,
  input wire logic [1:0] TX_CK_OE_OUT,
  input wire logic [1:0] TX_SD_OUT,
  input wire logic [1:0] TX_SD_OE_OUT,
  input wire logic [1:0] RX_FS_OUT,
  input wire logic [1:0] RX_FS_OE_OUT,
  input wire logic [1:0] RX_CK_OUT,
  input wire logic [1:0] RX_CK_OE_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);
  logic [`FFSP_CTRL_W-1:0] c0_r; // Shadow of port 0 control
  logic [`FFSP_CTRL_W-1:0] c1_r; // Shadow of port 1 control
  logic [4:0] ck_r; // Past levels of the port 1 tx clock
  logic [4:0] rk_r; // Past levels of the port 1 rx clock
  wire [5:0] u = {rk_r, RX_CK_OUT[1]}; // Newest rx level in bit 0
  // Rx sync launches opposite the sampling edge
  wire rlvl = c1_r[`FFSP_C_RX_FALL];
  wire rlaunched = |(rlvl ? (u[4:0] & ~u[5:1]) : (~u[4:0] & u[5:1]));
  wire wr = PSEL_IN && PENABLE_IN && PWRITE_IN; // Zero-wait write edge
  wire lvl = !c1_r[`FFSP_C_TX_FALL]; // Clock level just after a launch
  wire [5:0] v = {ck_r, TX_CK_OUT[1]}; // Newest level in bit 0
  // Launch edge in the last five cycles: the edge finder may lag the pin
  wire launched = |(lvl ? (v[4:0] & ~v[5:1]) : (~v[4:0] & v[5:1]));
  // Enables expected per pin kind, port 1 in the upper bit
  wire [1:0] tfs_d = {c1_r[`FFSP_C_TXFS_OUT], c0_r[`FFSP_C_TXFS_OUT]};
  wire [1:0] tck_d = {c1_r[`FFSP_C_TXCK_OUT], c0_r[`FFSP_C_TXCK_OUT]};
  wire [1:0] rfs_d = {c1_r[`FFSP_C_RXFS_OUT], c0_r[`FFSP_C_RXFS_OUT]};
  wire [1:0] rck_d = {c1_r[`FFSP_C_RXCK_OUT], c0_r[`FFSP_C_RXCK_OUT]};
  // Shadows follow the APB write edge
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      c0_r <= `FFSP_CTRL_RST;
      c1_r <= `FFSP_CTRL_RST;
      ck_r <= 5'h00;
      rk_r <= 5'h00;
    end else begin
      ck_r <= {ck_r[3:0], TX_CK_OUT[1]};
      rk_r <= {rk_r[3:0], RX_CK_OUT[1]};
      if (wr && PADDR_IN == `FFSP_CTRL0_OFS) begin
        c0_r <= PWDATA_IN[`FFSP_CTRL_W-1:0];
      end
      if (wr && PADDR_IN == `FFSP_CTRL1_OFS) begin
        c1_r <= PWDATA_IN[`FFSP_CTRL_W-1:0];
      end
    end
  end
  AST_TXFS_DIR: assert property (
    TX_FS_OE_OUT == tfs_d)
    else $error("tx sync enable does not follow control");
  AST_TXCK_DIR: assert property (
    TX_CK_OE_OUT == tck_d)
    else $error("tx clock enable does not follow control");
  AST_RXFS_DIR: assert property (
    RX_FS_OE_OUT == rfs_d)
    else $error("rx sync enable does not follow control");
  AST_RXCK_DIR: assert property (
    RX_CK_OE_OUT == rck_d)
    else $error("rx clock enable does not follow control");
  AST_SD_LOW: assert property (TX_SD_OUT == 2'b00)
    else $error("tx data drives high");
  AST_TXCK_RATE: assert property (
    (TX_CK_OE_OUT[1] && $changed(TX_CK_OUT[1])) |=> $stable(TX_CK_OUT[1])[*2]
    ##[1:37] ($changed(TX_CK_OUT[1]) || !TX_CK_OE_OUT[1]))
    else $error("generated clock out of range");
  AST_FS_EDGE: assert property (
    (TX_FS_OE_OUT[1] && $rose(TX_FS_OUT[1]) && $stable(c1_r)) |-> launched)
    else $error("tx sync off the launch edge");
  AST_SD_EDGE: assert property (
    (TX_CK_OE_OUT[1] && $changed(TX_SD_OE_OUT[1]) && $stable(c1_r)) |-> launched)
    else $error("tx data off the launch edge");
  AST_RXCK_RATE: assert property (
    (RX_CK_OE_OUT[1] && $changed(RX_CK_OUT[1])) |=> $stable(RX_CK_OUT[1])[*2]
    ##[1:37] ($changed(RX_CK_OUT[1]) || !RX_CK_OE_OUT[1]))
    else $error("generated rx clock out of range");
  AST_RXFS_EDGE: assert property (
    (RX_FS_OE_OUT[1] && $rose(RX_FS_OUT[1]) && $stable(c1_r)) |-> rlaunched)
    else $error("rx sync off the launch edge");
endmodule

bind ffsp_top ffsp_monitor u_mon (.CLK_SYS_IN, .SYS_RST_IN, .PSEL_IN, .PENABLE_IN,
  .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .TX_FS_OUT, .TX_FS_OE_OUT, .TX_CK_OUT,
  .TX_CK_OE_OUT, .TX_SD_OUT, .TX_SD_OE_OUT, .RX_FS_OUT, .RX_FS_OE_OUT, .RX_CK_OUT,
  .RX_CK_OE_OUT);
`default_nettype wire

// >>> ffsp_port.v
/*
  One fast framed serial port: transmit and receive directions with
  selectable pin directions and clock edges, and a two-entry buffer
  on each data path. Assumes pin inputs arrive raw from the pads.
*/
`default_nettype none
`include "ffsp_defs.vh"

module ffsp_port (
  input wire clk_in,
  input wire rst_in,
  input wire [`FFSP_CTRL_W-1:0] ctrl_in,
  input wire [`FFSP_WORD_W-1:0] tx_word_in,
  input wire tx_valid_in,
  output wire tx_ready_out,
  output wire [`FFSP_WORD_W-1:0] rx_word_out,
  output wire rx_valid_out,
  input wire rx_ready_in,
  output reg rx_overrun_out,
  input wire rx_overrun_clr_in,
  input wire tx_fs_in,
  output reg tx_fs_out,
  output wire tx_fs_oe_out,
  input wire tx_ck_in,
  output reg tx_ck_out,
  output wire tx_ck_oe_out,
  output wire tx_sd_oe_out,
  input wire rx_fs_in,
  output reg rx_fs_out,
  output wire rx_fs_oe_out,
  input wire rx_ck_in,
  output reg rx_ck_out,
  output wire rx_ck_oe_out,
  input wire rx_sd_in
);
  // Control fields
  wire en = ctrl_in[`FFSP_C_ENABLE];
  wire tx_fall = ctrl_in[`FFSP_C_TX_FALL];
  wire rx_fall = ctrl_in[`FFSP_C_RX_FALL];

  // Pins are driven only when chosen as outputs
  assign tx_fs_oe_out = ctrl_in[`FFSP_C_TXFS_OUT];
  assign tx_ck_oe_out = ctrl_in[`FFSP_C_TXCK_OUT];
  assign rx_fs_oe_out = ctrl_in[`FFSP_C_RXFS_OUT];
  assign rx_ck_oe_out = ctrl_in[`FFSP_C_RXCK_OUT];

  // Two-flop synchronisers for pad inputs
  reg [4:0] s1_r;
  reg [4:0] s2_r;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_r <= 5'h1F;
      s2_r <= 5'h1F;
    end else begin
      s1_r <= {tx_fs_in, tx_ck_in, rx_fs_in, rx_ck_in, rx_sd_in};
      s2_r <= s1_r;
    end
  end

  // Internal bit clock divider, shared by both directions
  reg [`FFSP_DIV_W-1:0] div_r;
  reg gen_ck_r;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_r <= 4'h0;
      gen_ck_r <= 1'b0;
    end else if (div_r == `FFSP_HALF_CYC - 1) begin
      div_r <= 4'h0;
      gen_ck_r <= ~gen_ck_r;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  // Effective clock levels: own generated or sampled pin
  wire tx_ck = tx_ck_oe_out ? gen_ck_r : s2_r[3];
  wire rx_ck = rx_ck_oe_out ? gen_ck_r : s2_r[1];
  reg tx_ck_d_r;
  reg rx_ck_d_r;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      // Match the synchroniser's pulled-up reset level: no false edge
      tx_ck_d_r <= 1'b1;
      rx_ck_d_r <= 1'b1;
      tx_ck_out <= 1'b0;
      rx_ck_out <= 1'b0;
    end else begin
      tx_ck_d_r <= tx_ck;
      rx_ck_d_r <= rx_ck;
      tx_ck_out <= gen_ck_r;
      rx_ck_out <= gen_ck_r;
    end
  end
  wire tx_rise = tx_ck & ~tx_ck_d_r;
  wire tx_fallx = ~tx_ck & tx_ck_d_r;
  wire rx_rise = rx_ck & ~rx_ck_d_r;
  wire rx_fallx = ~rx_ck & rx_ck_d_r;
  // Launch on chosen edge, sample sync on the other
  wire tx_launch = en & (tx_fall ? tx_fallx : tx_rise);
  wire tx_fs_samp = en & (tx_fall ? tx_rise : tx_fallx);
  // Rx data and incoming sync sampled on chosen edge
  wire rx_samp = en & (rx_fall ? rx_fallx : rx_rise);
  wire rx_launch = en & (rx_fall ? rx_rise : rx_fallx);

  // Transmit buffer: two entries; a word written while both are full is dropped
  wire [`FFSP_WORD_W-1:0] txb_data;
  wire txb_valid;
  reg txb_take;
  ffsp_buf2 u_txbuf (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_data_in(tx_word_in),
    .in_valid_in(tx_valid_in),
    .in_ready_out(tx_ready_out),
    .out_data_out(txb_data),
    .out_valid_out(txb_valid),
    .out_ready_in(txb_take)
  );

  // Transmit shifter and bit counter within the frame
  reg [7:0] tx_bit_r;
  reg [`FFSP_WORD_W-1:0] tx_sh_r;
  reg [2:0] tx_cnt_r;
  reg tx_sd_r;
  reg tx_run_r;
  wire tx_frame_start = tx_fs_oe_out ? (tx_bit_r == 8'h00) : (tx_fs_samp & s2_r[4]);
  always @* begin
    txb_take = tx_launch & (tx_cnt_r == 3'h0) & txb_valid & tx_run_r;
  end
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_bit_r <= 8'h00;
      tx_sh_r <= 8'hFF;
      tx_cnt_r <= 3'h0;
      tx_sd_r <= 1'b1;
      tx_run_r <= 1'b0;
      tx_fs_out <= 1'b0;
    end else if (!en) begin
      tx_bit_r <= 8'h00;
      tx_cnt_r <= 3'h0;
      tx_sd_r <= 1'b1;
      tx_run_r <= 1'b0;
      tx_fs_out <= 1'b0;
    end else begin
      // External sync seen on sampling edge aligns the next launch
      if (!tx_fs_oe_out && tx_frame_start) begin
        tx_run_r <= 1'b1;
        tx_cnt_r <= 3'h0;
      end
      if (tx_launch) begin
        if (tx_fs_oe_out) begin
          tx_run_r <= 1'b1;
          tx_fs_out <= (tx_bit_r == 8'h00);
          tx_bit_r <= (tx_bit_r == `FFSP_FRAME_BITS - 8'h01) ? 8'h00 : tx_bit_r + 8'h01;
        end
        if (tx_run_r) begin
          // Idle bits are ones, which leave the line released
          if (tx_cnt_r == 3'h0) begin
            tx_sd_r <= txb_valid ? txb_data[7] : 1'b1;
            tx_sh_r <= txb_valid ? {txb_data[6:0], 1'b1} : 8'hFF;
          end else begin
            tx_sd_r <= tx_sh_r[7];
            tx_sh_r <= {tx_sh_r[6:0], 1'b1};
          end
          tx_cnt_r <= tx_cnt_r + 3'h1;
        end
      end
    end
  end
  // Open drain: enable only for a zero bit
  assign tx_sd_oe_out = ~tx_sd_r;

  // Receive side: own sync generation and data sampling
  reg [7:0] rx_bit_r;
  reg [`FFSP_WORD_W-1:0] rx_sh_r;
  reg [2:0] rx_cnt_r;
  reg rx_run_r;
  reg rx_push_r;
  reg [`FFSP_WORD_W-1:0] rx_word_r;
  wire rxb_ready;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_bit_r <= 8'h00;
      rx_sh_r <= 8'h00;
      rx_cnt_r <= 3'h0;
      rx_run_r <= 1'b0;
      rx_push_r <= 1'b0;
      rx_word_r <= 8'h00;
      rx_fs_out <= 1'b0;
    end else if (!en) begin
      rx_bit_r <= 8'h00;
      rx_cnt_r <= 3'h0;
      rx_run_r <= 1'b0;
      rx_push_r <= 1'b0;
      rx_fs_out <= 1'b0;
    end else begin
      rx_push_r <= 1'b0;
      // Own sync launched opposite to the sampling edge
      if (rx_launch && rx_fs_oe_out) begin
        rx_fs_out <= (rx_bit_r == 8'h00);
        rx_bit_r <= (rx_bit_r == `FFSP_FRAME_BITS - 8'h01) ? 8'h00 : rx_bit_r + 8'h01;
      end
      if (rx_samp) begin
        if ((rx_fs_oe_out ? rx_fs_out : s2_r[2])) begin
          rx_run_r <= 1'b1;
          rx_cnt_r <= 3'h1;
          rx_sh_r <= {rx_sh_r[6:0], s2_r[0]};
        end else if (rx_run_r) begin
          rx_sh_r <= {rx_sh_r[6:0], s2_r[0]};
          rx_cnt_r <= rx_cnt_r + 3'h1;
          if (rx_cnt_r == 3'h7) begin
            rx_word_r <= {rx_sh_r[6:0], s2_r[0]};
            rx_push_r <= 1'b1;
          end
        end
      end
    end
  end
  // Overrun when a word arrives with both buffer slots full; set beats clear
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_overrun_out <= 1'b0;
    end else if (rx_push_r && !rxb_ready) begin
      rx_overrun_out <= 1'b1;
    end else if (rx_overrun_clr_in) begin
      rx_overrun_out <= 1'b0;
    end
  end

  // Receive buffer toward software
  ffsp_buf2 u_rxbuf (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_data_in(rx_word_r),
    .in_valid_in(rx_push_r),
    .in_ready_out(rxb_ready),
    .out_data_out(rx_word_out),
    .out_valid_out(rx_valid_out),
    .out_ready_in(rx_ready_in)
  );
endmodule

// Two-entry valid/ready buffer, data from flops
module ffsp_buf2 (
  input wire clk_in,
  input wire rst_in,
  input wire [`FFSP_WORD_W-1:0] in_data_in,
  input wire in_valid_in,
  output wire in_ready_out,
  output wire [`FFSP_WORD_W-1:0] out_data_out,
  output wire out_valid_out,
  input wire out_ready_in
);
  reg [`FFSP_WORD_W-1:0] mem_r [0:1];
  reg rd_r;
  reg wr_r;
  reg [1:0] cnt_r;
  wire push = in_valid_in & (cnt_r != 2'h2);
  wire pop = out_ready_in & (cnt_r != 2'h0);
  assign in_ready_out = (cnt_r != 2'h2);
  assign out_valid_out = (cnt_r != 2'h0);
  assign out_data_out = mem_r[rd_r];
  // Pointer and count update
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      cnt_r <= 2'h0;
      mem_r[0] <= 8'h00;
      mem_r[1] <= 8'h00;
    end else begin
      if (push) begin
        mem_r[wr_r] <= in_data_in;
        wr_r <= ~wr_r;
      end
      if (pop) begin
        rd_r <= ~rd_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// >>> ffsp_top.v
/*
  Top of the fast framed serial port pair: APB slave with control,
  status and data registers, and two port instances.
  Assumes an APB master on CLK_SYS_IN; pads resolve enables.
*/
`default_nettype none
`include "ffsp_defs.vh"

module ffsp_top (
  input wire CLK_SYS_IN,
  input wire SYS_RST_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [11:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output reg [31:0] PRDATA_OUT,
  output wire PREADY_OUT,
  output wire PSLVERR_OUT,
  input wire [1:0] TX_FS_IN,
  output wire [1:0] TX_FS_OUT,
  output wire [1:0] TX_FS_OE_OUT,
  input wire [1:0] TX_CK_IN,
  output wire [1:0] TX_CK_OUT,
  output wire [1:0] TX_CK_OE_OUT,
  output wire [1:0] TX_SD_OUT,
  output wire [1:0] TX_SD_OE_OUT,
  input wire [1:0] RX_FS_IN,
  output wire [1:0] RX_FS_OUT,
  output wire [1:0] RX_FS_OE_OUT,
  input wire [1:0] RX_CK_IN,
  output wire [1:0] RX_CK_OUT,
  output wire [1:0] RX_CK_OE_OUT,
  input wire [1:0] RX_SD_IN
);
  // Per-port control, reset to all inputs
  reg [`FFSP_CTRL_W-1:0] ctrl_r [0:1];
  wire [1:0] tx_ready;
  wire [1:0] rx_valid;
  wire [1:0] overrun;
  wire [`FFSP_WORD_W-1:0] rx_word [0:1];
  wire acc = PSEL_IN & PENABLE_IN;
  wire wr = acc & PWRITE_IN;
  wire rd = acc & ~PWRITE_IN;
  wire hit = (PADDR_IN[11:5] == 7'h00) & (PADDR_IN[1:0] == 2'h0);
  // Zero wait states; unmapped addresses answer with an error
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = acc & ~hit;
  // Open drain data only ever drives low
  assign TX_SD_OUT = 2'h0;

  // Control register writes
  always @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ctrl_r[0] <= `FFSP_CTRL_RST;
      ctrl_r[1] <= `FFSP_CTRL_RST;
    end else if (wr && PADDR_IN == `FFSP_CTRL0_OFS) begin
      ctrl_r[0] <= PWDATA_IN[`FFSP_CTRL_W-1:0];
    end else if (wr && PADDR_IN == `FFSP_CTRL1_OFS) begin
      ctrl_r[1] <= PWDATA_IN[`FFSP_CTRL_W-1:0];
    end
  end

  // Read mux over flops; valid while the address is held
  always @* begin
    PRDATA_OUT = 32'h0000_0000;
    case (PADDR_IN)
      `FFSP_CTRL0_OFS: PRDATA_OUT = {25'h0, ctrl_r[0]};
      `FFSP_CTRL1_OFS: PRDATA_OUT = {25'h0, ctrl_r[1]};
      `FFSP_STAT0_OFS: PRDATA_OUT = {29'h0, overrun[0], rx_valid[0], tx_ready[0]};
      `FFSP_STAT1_OFS: PRDATA_OUT = {29'h0, overrun[1], rx_valid[1], tx_ready[1]};
      `FFSP_RXDATA0_OFS: PRDATA_OUT = {24'h0, rx_word[0]};
      `FFSP_RXDATA1_OFS: PRDATA_OUT = {24'h0, rx_word[1]};
      default: PRDATA_OUT = 32'h0000_0000;
    endcase
  end

  // Two identical independent ports
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gp
      ffsp_port u_port (
        .clk_in(CLK_SYS_IN),
        .rst_in(SYS_RST_IN),
        .ctrl_in(ctrl_r[g]),
        .tx_word_in(PWDATA_IN[`FFSP_WORD_W-1:0]),
        .tx_valid_in(wr && PADDR_IN == (`FFSP_TXDATA0_OFS + 12'h004 * g)),
        .tx_ready_out(tx_ready[g]),
        .rx_word_out(rx_word[g]),
        .rx_valid_out(rx_valid[g]),
        .rx_ready_in(rd && PADDR_IN == (`FFSP_RXDATA0_OFS + 12'h004 * g)),
        .rx_overrun_out(overrun[g]),
        .rx_overrun_clr_in(wr && PADDR_IN == (`FFSP_STAT0_OFS + 12'h004 * g)
          && PWDATA_IN[`FFSP_S_RX_OVERRUN]),
        .tx_fs_in(TX_FS_IN[g]),
        .tx_fs_out(TX_FS_OUT[g]),
        .tx_fs_oe_out(TX_FS_OE_OUT[g]),
        .tx_ck_in(TX_CK_IN[g]),
        .tx_ck_out(TX_CK_OUT[g]),
        .tx_ck_oe_out(TX_CK_OE_OUT[g]),
        .tx_sd_oe_out(TX_SD_OE_OUT[g]),
        .rx_fs_in(RX_FS_IN[g]),
        .rx_fs_out(RX_FS_OUT[g]),
        .rx_fs_oe_out(RX_FS_OE_OUT[g]),
        .rx_ck_in(RX_CK_IN[g]),
        .rx_ck_out(RX_CK_OUT[g]),
        .rx_ck_oe_out(RX_CK_OE_OUT[g]),
        .rx_sd_in(RX_SD_IN[g])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// >>> ffsp_top_tb.sv
/*
  Testbench for ffsp_top: APB master, framer on port 0, own clocks and
  loopback on port 1, queued expectations judged by watchers.
  Assumes pads with pull-ups; every pin enable is resolved here.
*/
`default_nettype none
`include "ffsp_defs.vh"
module ffsp_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0; // 40 MHz system clock
  logic rst = 1'b1; // Held for six cycles
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0;
  wire [31:0] prd;
  wire prdy, perr, f_ck, f_tfs, f_rfs, f_rsd, f_stb;
  wire [1:0] tfs, tfs_oe, tck, tck_oe, tsd, tsd_oe, rfs, rfs_oe, rck, rck_oe;
  wire [7:0] f_got;
  wire [1:0] tsd_w = ~tsd_oe | tsd; // Open drain with pull-up
  // Device side when enabled, else framer on port 0, pull-up on port 1
  wire [1:0] tfs_w = (tfs_oe & tfs) | (~tfs_oe & {1'b1, f_tfs});
  wire [1:0] tck_w = (tck_oe & tck) | (~tck_oe & {1'b1, f_ck});
  wire [1:0] rfs_w = (rfs_oe & rfs) | (~rfs_oe & {1'b1, f_rfs});
  wire [1:0] rck_w = (rck_oe & rck) | (~rck_oe & {1'b1, f_ck});
  logic [32:0] rd_q[$]; // Expected {slave error, read data}
  logic [7:0] tx_q[$]; // Words expected at the framer
  int err_count = 0;
  int compares = 0;
  logic [7:0] tw, rw;
  logic [31:0] cfg [2] = '{32'h4F, 32'h7F}; // Port 1 drives all, rising then falling
  always #12.5 clk = ~clk;
  ffsp_top u_dut (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
    .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .TX_FS_IN(tfs_w), .TX_FS_OUT(tfs),
    .TX_FS_OE_OUT(tfs_oe), .TX_CK_IN(tck_w), .TX_CK_OUT(tck), .TX_CK_OE_OUT(tck_oe),
    .TX_SD_OUT(tsd), .TX_SD_OE_OUT(tsd_oe), .RX_FS_IN(rfs_w), .RX_FS_OUT(rfs),
    .RX_FS_OE_OUT(rfs_oe), .RX_CK_IN(rck_w), .RX_CK_OUT(rck), .RX_CK_OE_OUT(rck_oe),
    .RX_SD_IN({tsd_w[1], f_rsd}));
  ffsp_framer u_frm (.tx_line(tsd_w[0]), .ck(f_ck), .tx_fs(f_tfs), .rx_fs(f_rfs),
    .rx_sd(f_rsd), .got(f_got), .got_stb(f_stb));
  task automatic cmp(input string what, input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [32:0] g, input logic [32:0] e);
    cmp("read", g, e);
  endtask
  task automatic chk_word(input logic [7:0] g, input logic [7:0] e);
    cmp("tx word", {25'h0, g}, {25'h0, e});
  endtask
  // Enables are looked at mid-cycle, clear of the edge's updates
  task automatic chk_pins(input logic [7:0] e);
    @(negedge clk);
    cmp("enables", {25'h0, rck_oe, rfs_oe, tck_oe, tfs_oe}, {25'h0, e});
  endtask
  // One APB transfer; held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic end_of_test;
    $display("compares %0d, errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Read data is taken at the access edge
  always @(posedge clk) begin
    if (psel && pen && !pwr && prdy === 1'b1) begin
      chk_rd({perr, prd}, rd_q.pop_front());
    end
  end
  // Each captured frame word against the oldest queued word
  always @(posedge f_stb) begin
    chk_word(f_got, tx_q.pop_front());
  end
  // Cuts a hang short
  initial begin
    repeat (10000) @(posedge clk);
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    void'($urandom(32'h28AE));
    chk_pins(8'h00);
    rd(`FFSP_CTRL0_OFS, 33'h0);
    rd(`FFSP_CTRL1_OFS, 33'h0);
    rd(`FFSP_STAT0_OFS, 33'h1);
    rd(12'h020, 33'h1_0000_0000); // Unmapped: error, data zero
    // Port 0 slaved to the framer, both launch edges
    for (int f = 0; f < 2; f++) begin
      tw = 8'($urandom);
      rw = 8'($urandom);
      apb(1'b1, `FFSP_CTRL0_OFS, 32'h40 | (32'(f) << 4) | (32'(f) << 5));
      apb(1'b1, `FFSP_TXDATA0_OFS, {24'h0, tw});
      tx_q.push_back(tw);
      u_frm.frame(f[0], rw);
      rd(`FFSP_STAT0_OFS, 33'h3);
      rd(`FFSP_RXDATA0_OFS, {25'h0, rw});
    end
    // Port 1 buffer fills while idle: the third word is refused
    repeat (3) apb(1'b1, `FFSP_TXDATA1_OFS, {24'h0, 8'($urandom)});
    rd(`FFSP_STAT1_OFS, 33'h0);
    // Port 1 sources clocks and syncs on its own
    foreach (cfg[i]) begin
      apb(1'b1, `FFSP_CTRL1_OFS, cfg[i]);
      repeat (4) @(posedge clk);
      chk_pins(8'hAA);
      rd(`FFSP_CTRL1_OFS, {1'b0, cfg[i]});
      repeat (700) @(posedge clk);
    end
    apb(1'b1, `FFSP_CTRL1_OFS, 32'h0);
    repeat (4) @(posedge clk);
    chk_pins(8'h00);
    // Unread loopback words filled the rx buffer: overrun set, then cleared
    rd(`FFSP_STAT1_OFS, 33'h7);
    apb(1'b1, `FFSP_STAT1_OFS, 32'h4);
    rd(`FFSP_STAT1_OFS, 33'h3);
    end_of_test();
  end
endmodule
`default_nettype wire
